// ---- logic/nor_flash_cmd_ctrl.sv ----
// Purpose: host side command controller for a 16-bit parallel nor flash
// Assumes: one request at a time; flash status polled by the user via reads
// Notes:   issues unlock, command and data cycles; tracks the flash's mode
`timescale 1ns/100ps
`default_nettype none
// Contract
// [R01] Id query entry only issued in read or erase-suspend read, never while busy.
// [R02] Id entry is two unlocks plus query command; reads then repeat freely.
// [R03] Id reads at low address 00h and 01h give maker and device codes.
// [R04] Id read at sector group with low 02h gives protection flag.
// [R05] Id mode ends on reset command, back to read or suspend read.
// [R06] Secure region entry three cycles, exit four cycles.
// [R07] Word program is two unlocks, set-up, then address and data.
// [R08] Flash times program pulses itself; controller just waits on ready.
// [R09] After program the flash returns to read; busy shown on ready pin.
// [R10] No commands sent while program runs; hardware reset aborts it.
// [R11] Program only clears bits; controller does not flag attempts to set bits.
// [R12] Unlock bypass entry is two unlocks plus command 20h.
// [R13] Bypass program is A0h then address and data, repeatable.
// [R14] In bypass only program and exit (90h then 00h) are sent.
// [R15] Acceleration pin raised puts flash into bypass automatically.
// [R16] Chip erase is six writes ending with chip erase command.
// [R17] Flash preprograms before erase; controller sends nothing extra.
// [R18] No commands during chip erase; hardware reset aborts it.
// [R19] Sector erase is six writes, last carries sector address and 30h.
// [R20] More sectors added only while 50 us window still open.
// [R21] Other commands in the window cancel the erase; controller avoids that.
// [R22] While sector erase runs, only suspend is sent.
// [R23] Unlock writes go to 555h then 2AAh.
// [R24] Suspend in the window suspends the erase at once.
// [R25] Command bytes follow the flash command table.
module nor_flash_cmd_ctrl
  import flash_cmd_pkg::*;
#(
  parameter int WINDOW_CYC = SE_WINDOW_CYC        // shorten for simulation
) (
  input  wire logic              clk,             // system clock
  input  wire logic              sys_rst,         // sync reset
  input  wire logic              req_valid,       // user request
  input  wire cmd_req_t          req,             // operation, address, data
  output logic                   req_ready,       // request taken when high
  output logic                   resp_valid,      // one-cycle completion pulse
  output logic [DATA_W-1:0]      resp_data,       // read data
  output logic                   resp_err,        // request refused
  output mode_t                  mode,            // tracked flash mode
  input  wire logic              accel_req,       // user asks accelerated program
  output logic                   acceleration_pin, // high voltage enable
  output logic                   flash_rst_n,     // hardware reset to flash
  input  wire logic              ready_busy_n_output, // flash ready pin
  output logic                   ce_n,            // chip select
  output logic                   we_n,            // write strobe
  output logic                   oe_n,            // read strobe
  output logic [ADDR_W-1:0]      addr,            // address pins
  output logic [DATA_W-1:0]      dq_o,            // data out
  output logic                   dq_oe_n,         // data enable, low drives
  input  wire logic [DATA_W-1:0] dq_i             // data in
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_BUSY, S_DONE} st_t;
  st_t               st_q, st_d;
  logic [2:0]        idx_q, idx_d, len_q, len_d;
  cmd_req_t          cur_q, cur_d;
  mode_t             m_q, m_d;
  logic              err_q, err_d;
  logic              acc_q, acc_d;
  logic              rbn_q;
  logic              start;
  bus_cyc_t          cyc;
  logic              cyc_done, wr_rise;
  logic [DATA_W-1:0] rd_data;
  logic              win_restart, win_clear, win_open, win_margin;

  // address and data of step i of a sequence
  function automatic bus_cyc_t step(input cmd_req_t r, input logic [2:0] i);
    bus_cyc_t c;
    c = '{addr: '0, data: '0, rd: 1'b0};
    unique case (r.op)
      OP_READ, OP_ID_READ: begin
        c.addr = r.addr;
        c.rd   = 1'b1;
      end
      OP_RESET: c.data = {8'h00, CMD_RESET};                  // R05
      OP_SUSPEND: c.data = {8'h00, CMD_SUSPEND};              // R24
      OP_SECT_ADD: begin
        c.addr = r.addr;
        c.data = {8'h00, CMD_SECT_ERASE};                     // R20
      end
      OP_BYPASS_PROG: begin
        c.addr = r.addr;                                      // R13
        c.data = (i == 3'd0) ? {8'h00, CMD_PROGRAM} : r.data;
      end
      OP_BYPASS_EXIT: c.data = {8'h00, (i == 3'd0) ? CMD_ID_QUERY : CMD_EXIT_DATA}; // R14
      default: begin
        // unlock pairs at steps 0,1 and, for erases, 3,4
        if (i == 3'd0 || (i == 3'd3 && r.op inside {OP_CHIP_ERASE, OP_SECT_ERASE})) begin
          c.addr = ADDR_W'(UNLOCK_ADDR1);                     // R23
          c.data = {8'h00, UNLOCK_DATA1};
        end else if (i == 3'd1 || i == 3'd4) begin
          c.addr = ADDR_W'(UNLOCK_ADDR2);                     // R23
          c.data = {8'h00, UNLOCK_DATA2};
        end else if (i == 3'd2) begin
          c.addr = ADDR_W'(UNLOCK_ADDR1);
          unique case (r.op)                                  // R25
            OP_ID_ENTER:     c.data = {8'h00, CMD_ID_QUERY};
            OP_SECURE_ENTER: c.data = {8'h00, CMD_SECURE_IN};
            OP_SECURE_EXIT:  c.data = {8'h00, CMD_ID_QUERY};
            OP_PROGRAM:      c.data = {8'h00, CMD_PROGRAM};
            OP_BYPASS_ENTER: c.data = {8'h00, CMD_BYPASS};
            default:         c.data = {8'h00, CMD_ERASE_SETUP};
          endcase
        end else if (r.op == OP_SECURE_EXIT) begin
          c.data = {8'h00, CMD_EXIT_DATA};                    // R06
        end else if (r.op == OP_PROGRAM) begin
          c.addr = r.addr;                                    // R07
          c.data = r.data;
        end else if (r.op == OP_CHIP_ERASE) begin
          c.addr = ADDR_W'(UNLOCK_ADDR1);
          c.data = {8'h00, CMD_CHIP_ERASE};                   // R16
        end else begin
          c.addr = r.addr;
          c.data = {8'h00, CMD_SECT_ERASE};                   // R19
        end
      end
    endcase
    return c;
  endfunction

  function automatic logic [2:0] seq_len(input op_t op);
    unique case (op)
      OP_READ, OP_ID_READ, OP_RESET, OP_SUSPEND, OP_SECT_ADD: seq_len = 3'd1;
      OP_BYPASS_PROG, OP_BYPASS_EXIT:                         seq_len = 3'd2;
      OP_ID_ENTER, OP_SECURE_ENTER, OP_BYPASS_ENTER:          seq_len = 3'd3;
      OP_SECURE_EXIT, OP_PROGRAM:                             seq_len = 3'd4;
      default:                                                seq_len = 3'd6;
    endcase
  endfunction

  // legality against the tracked mode
  function automatic logic allowed(input op_t op, input mode_t m, input logic busy);
    logic bp;
    bp = m.bypass_mode;
    if (m.window_open) allowed = (op == OP_SECT_ADD) || (op == OP_SUSPEND) || (op == OP_READ); // R21
    else if (busy) allowed = (op == OP_READ);                                   // R10 R18 R22
    else if (bp) allowed = (op == OP_BYPASS_PROG) || (op == OP_BYPASS_EXIT) || (op == OP_READ); // R14
    else if (m.id_mode) allowed = (op == OP_ID_READ) || (op == OP_RESET);       // R05
    else unique case (op)
      OP_ID_ENTER, OP_READ, OP_RESET, OP_PROGRAM: allowed = 1'b1;               // R01
      OP_SECURE_ENTER, OP_BYPASS_ENTER, OP_CHIP_ERASE, OP_SECT_ERASE:
        allowed = !m.suspended;
      OP_SECURE_EXIT: allowed = m.secure_mode;
      default: allowed = 1'b0;
    endcase
  endfunction

  flash_bus_cycle u_bus (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (start),
    .cyc     (cyc),
    .done    (cyc_done),
    .wr_rise (wr_rise),
    .rd_data (rd_data),
    .ce_n    (ce_n),
    .we_n    (we_n),
    .oe_n    (oe_n),
    .addr    (addr),
    .dq_o    (dq_o),
    .dq_oe_n (dq_oe_n),
    .dq_i    (dq_i)
  );

  erase_window_timer #(.WINDOW_CYC(WINDOW_CYC)) u_win (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .restart   (win_restart),
    .clear     (win_clear),
    .open_o    (win_open),
    .margin_ok (win_margin)
  );

  assign cyc         = step(cur_q, idx_q);
  assign start       = (st_q == S_ISSUE);
  assign req_ready   = (st_q == S_IDLE);
  assign win_restart = wr_rise && (idx_q == len_q - 3'd1) &&
                       (cur_q.op == OP_SECT_ERASE || cur_q.op == OP_SECT_ADD); // R20
  assign win_clear   = wr_rise && (cur_q.op == OP_SUSPEND);                      // R24

  always_comb begin
    st_d  = st_q;
    idx_d = idx_q;
    len_d = len_q;
    cur_d = cur_q;
    m_d   = m_q;
    err_d = 1'b0;
    acc_d = accel_req;
    m_d.window_open = win_open || win_restart;
    if (accel_req) m_d.bypass_mode = 1'b1;                                    // R15
    unique case (st_q)
      S_IDLE: if (req_valid) begin
        cur_d = req;
        idx_d = 3'd0;
        len_d = seq_len(req.op);
        if (!allowed(req.op, m_q, !rbn_q) ||
            (req.op == OP_SECT_ADD && !win_margin)) begin                    // R20
          err_d = 1'b1;
          st_d  = S_DONE;
        end else st_d = S_ISSUE;
      end
      S_ISSUE: st_d = S_WAIT;
      S_WAIT: if (cyc_done) begin
        if (idx_q == len_q - 3'd1) begin
          st_d = S_DONE;
          unique case (cur_q.op)
            OP_ID_ENTER:     m_d.id_mode = 1'b1;                             // R02
            OP_RESET:        m_d.id_mode = 1'b0;                             // R05
            OP_SECURE_ENTER: m_d.secure_mode = 1'b1;                         // R06
            OP_SECURE_EXIT:  m_d.secure_mode = 1'b0;                         // R06
            OP_BYPASS_ENTER: m_d.bypass_mode = 1'b1;                         // R12
            OP_BYPASS_EXIT:  m_d.bypass_mode = accel_req;                    // R14
            OP_SUSPEND:      m_d.suspended = 1'b1;                           // R24
            OP_PROGRAM, OP_BYPASS_PROG, OP_CHIP_ERASE: st_d = S_BUSY;        // R08
            default: ;
          endcase
        end else begin
          idx_d = idx_q + 3'd1;
          st_d  = S_ISSUE;
        end
      end
      S_BUSY: if (rbn_q && !cyc_done) st_d = S_DONE;                         // R09
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q  <= S_IDLE;
      idx_q <= 3'd0;
      len_q <= 3'd1;
      cur_q <= '0;
      m_q   <= '0;
      err_q <= 1'b0;
      acc_q <= 1'b0;
      rbn_q <= 1'b1;
    end else begin
      st_q  <= st_d;
      idx_q <= idx_d;
      len_q <= len_d;
      cur_q <= cur_d;
      m_q   <= m_d;
      err_q <= err_d || (st_d == S_DONE && err_q);
      acc_q <= acc_d;
      rbn_q <= ready_busy_n_output;
    end
  end

  // busy wait needs a settle cycle before ready is trusted
  assign resp_valid       = (st_q == S_DONE);
  assign resp_err         = err_q;
  assign resp_data        = rd_data;
  assign mode             = m_q;
  assign acceleration_pin = acc_q;                                            // R15
  assign flash_rst_n      = !sys_rst;                                         // R10 R18

  a_no_cmd_busy: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (start && !rbn_q) |-> cyc.rd) else $error("write issued while flash busy");
  a_id_entry_mode: assert property (@(posedge clk) disable iff (sys_rst) // R02
    (st_q == S_WAIT && cyc_done && cur_q.op == OP_ID_ENTER && idx_q == 3'd2) |=> m_q.id_mode)
    else $error("id mode not tracked");
  a_unlock_addr: assert property (@(posedge clk) disable iff (sys_rst) // R23
    (start && idx_q == 3'd1 && cur_q.op == OP_PROGRAM) |-> cyc.addr[11:0] == UNLOCK_ADDR2)
    else $error("second unlock address wrong");
  a_prog_data: assert property (@(posedge clk) disable iff (sys_rst) // R07
    (start && idx_q == 3'd3 && cur_q.op == OP_PROGRAM) |-> cyc.data == cur_q.data)
    else $error("program data not on fourth write");
  a_bypass_cmd: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (start && idx_q == 3'd0 && cur_q.op == OP_BYPASS_PROG) |-> cyc.data[7:0] == CMD_PROGRAM)
    else $error("bypass program command wrong");
  a_window_only: assert property (@(posedge clk) disable iff (sys_rst) // R21
    (start && m_q.window_open) |-> (cur_q.op inside {OP_SECT_ADD, OP_SUSPEND, OP_READ}))
    else $error("foreign command in erase window");
  a_sect_last: assert property (@(posedge clk) disable iff (sys_rst) // R19
    (start && idx_q == 3'd5 && cur_q.op == OP_SECT_ERASE) |-> cyc.data[7:0] == CMD_SECT_ERASE)
    else $error("sector erase command wrong");
  a_reset_exits: assert property (@(posedge clk) disable iff (sys_rst) // R05
    (st_q == S_WAIT && cyc_done && cur_q.op == OP_RESET) |=> !m_q.id_mode)
    else $error("reset did not leave id mode");
endmodule
`default_nettype wire

// ---- inc/flash_cmd_pkg.sv ----
// Purpose: constants and carriers for the parallel nor flash command controller
// Assumes: 16-bit flash bus, 100 MHz controller clock
// Notes:   command bytes and unlock addresses of the flash command set
package flash_cmd_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          ADDR_W          = 22;
  localparam int          DATA_W          = 16;
  localparam logic [11:0] UNLOCK_ADDR1    = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2    = 12'h2aa;
  localparam logic [7:0]  UNLOCK_DATA1    = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA2    = 8'h55;
  localparam logic [7:0]  CMD_ID_QUERY    = 8'h90;
  localparam logic [7:0]  CMD_SECURE_IN   = 8'h88;
  localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
  localparam logic [7:0]  CMD_RESET       = 8'hf0;
  localparam logic [7:0]  CMD_BYPASS      = 8'h20;
  localparam logic [7:0]  CMD_EXIT_DATA   = 8'h00;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0]  ID_MANUF_LOW    = 8'h00;
  localparam logic [7:0]  ID_DEVICE_LOW   = 8'h01;
  localparam logic [7:0]  ID_PROTECT_LOW  = 8'h02;
  // sector erase accumulation window
  localparam int          SE_WINDOW_US    = 50;
  localparam int          SE_WINDOW_CYC   = SE_WINDOW_US * 1000 / CLK_PERIOD_NS;
  // bus write/read pulse timing in cycles
  localparam int          WR_SETUP_CYC    = 2;
  localparam int          WR_PULSE_CYC    = 4;
  localparam int          WR_HOLD_CYC     = 2;
  localparam int          RD_ACCESS_CYC   = 10;

  typedef enum logic [3:0] {
    OP_READ, OP_ID_ENTER, OP_ID_READ, OP_SECURE_ENTER, OP_SECURE_EXIT, OP_RESET,
    OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROG, OP_BYPASS_EXIT, OP_CHIP_ERASE,
    OP_SECT_ERASE, OP_SECT_ADD, OP_SUSPEND
  } op_t;

  typedef struct packed {
    op_t                 op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } cmd_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                rd;
  } bus_cyc_t;

  typedef struct packed {
    logic                id_mode;
    logic                secure_mode;
    logic                bypass_mode;
    logic                suspended;
    logic                window_open;
  } mode_t;
endpackage

// ---- logic/flash_bus_cycle.sv ----
// Purpose: one asynchronous flash bus cycle (write or read) from the clock
// Assumes: strobes active low, data bus tristated while reading
// Notes:   write data latched by the flash on the rising write strobe
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
  import flash_cmd_pkg::*;
(
  input  wire logic              clk,       // system clock
  input  wire logic              sys_rst,   // sync reset
  input  wire logic              start,     // begin one cycle
  input  wire bus_cyc_t          cyc,       // address, data, direction
  output logic                   done,      // one-cycle pulse at end
  output logic                   wr_rise,   // pulse on rising write strobe
  output logic [DATA_W-1:0]      rd_data,   // captured read data
  output logic                   ce_n,      // chip select
  output logic                   we_n,      // write strobe
  output logic                   oe_n,      // read strobe
  output logic [ADDR_W-1:0]      addr,      // address pins
  output logic [DATA_W-1:0]      dq_o,      // data out
  output logic                   dq_oe_n,   // data enable, low drives
  input  wire logic [DATA_W-1:0] dq_i       // data in
);
  typedef enum logic [2:0] {B_IDLE, B_SETUP, B_PULSE, B_HOLD, B_READ} bst_t;
  bst_t                bst_q, bst_d;
  logic [7:0]          cnt_q, cnt_d;
  logic                rd_q, rd_d;
  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic [DATA_W-1:0]   dat_q, dat_d, rdd_q, rdd_d;

  always_comb begin
    bst_d   = bst_q;
    cnt_d   = cnt_q;
    rd_d    = rd_q;
    addr_d  = addr_q;
    dat_d   = dat_q;
    rdd_d   = rdd_q;
    done    = 1'b0;
    wr_rise = 1'b0;
    unique case (bst_q)
      B_IDLE: if (start) begin
        addr_d = cyc.addr;
        dat_d  = cyc.data;
        rd_d   = cyc.rd;
        cnt_d  = 8'(WR_SETUP_CYC);
        bst_d  = cyc.rd ? B_READ : B_SETUP;
        if (cyc.rd) cnt_d = 8'(RD_ACCESS_CYC);
      end
      B_SETUP: if (cnt_q == 8'h01) begin
        cnt_d = 8'(WR_PULSE_CYC);
        bst_d = B_PULSE;
      end else cnt_d = cnt_q - 8'h01;
      B_PULSE: if (cnt_q == 8'h01) begin
        cnt_d   = 8'(WR_HOLD_CYC);
        bst_d   = B_HOLD;
        wr_rise = 1'b1;
      end else cnt_d = cnt_q - 8'h01;
      B_HOLD: if (cnt_q == 8'h01) begin
        bst_d = B_IDLE;
        done  = 1'b1;
      end else cnt_d = cnt_q - 8'h01;
      B_READ: if (cnt_q == 8'h01) begin
        rdd_d = dq_i;
        bst_d = B_IDLE;
        done  = 1'b1;
      end else cnt_d = cnt_q - 8'h01;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bst_q  <= B_IDLE;
      cnt_q  <= 8'h00;
      rd_q   <= 1'b0;
      addr_q <= '0;
      dat_q  <= '0;
      rdd_q  <= '0;
    end else begin
      bst_q  <= bst_d;
      cnt_q  <= cnt_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
      dat_q  <= dat_d;
      rdd_q  <= rdd_d;
    end
  end

  assign ce_n    = (bst_q == B_IDLE);
  assign we_n    = (bst_q != B_PULSE);
  assign oe_n    = (bst_q != B_READ);
  assign addr    = addr_q;
  assign dq_o    = dat_q;
  assign dq_oe_n = (bst_q == B_IDLE) || rd_q;
  assign rd_data = rdd_q;
endmodule
`default_nettype wire

// ---- logic/erase_window_timer.sv ----
// Purpose: tracks the sector erase accumulation window since the last write
// Assumes: restart pulses on the rising strobe of each write carrying a sector address and 30h
// Notes:   open_o falls on expiry or clear and stays low until the next restart
`timescale 1ns/100ps
`default_nettype none
module erase_window_timer #(
  parameter int WINDOW_CYC = 5000       // window length in clock cycles
) (
  input  wire logic clk,                // system clock
  input  wire logic sys_rst,            // sync reset
  input  wire logic restart,            // start or restart window
  input  wire logic clear,              // close window without expiry
  output logic      open_o,             // window is running
  output logic      margin_ok           // still room for another write
);
  localparam int CW = $clog2(WINDOW_CYC + 1);
  localparam int MARGIN = WINDOW_CYC / 5;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (restart) cnt_d = CW'(WINDOW_CYC);
    else if (clear) cnt_d = '0;
    else if (cnt_q != '0) cnt_d = cnt_q - CW'(1);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

  assign open_o    = (cnt_q != '0);
  assign margin_ok = (cnt_q > CW'(MARGIN));
endmodule
`default_nettype wire

// ---- tb/flash_device_model.sv ----
// Purpose: behavioural parallel nor flash on the far side of the controller
// Assumes: strobes sampled on clk; writes taken on the rising write strobe
// Notes:   id codes are arbitrary; released data bus toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module flash_device_model
  import flash_cmd_pkg::*;
#(
  parameter logic [15:0] MANUF = 16'h00a5, // arbitrary
  parameter logic [15:0] DEVID = 16'h5a3c, // arbitrary
  parameter int          WIN   = 200       // erase window cycles
) (
  input  wire logic              clk,    // clock
  input  wire logic              rst_n,  // hardware reset
  input  wire logic              accel,  // acceleration pin
  input  wire logic              ce_n,   // chip select
  input  wire logic              we_n,   // write strobe
  input  wire logic              oe_n,   // read strobe
  input  wire logic [ADDR_W-1:0] addr,   // address
  input  wire logic [DATA_W-1:0] dq,     // data in
  output logic [DATA_W-1:0]      dq_out, // data out
  output logic                   rdy     // ready pin
);
  logic [15:0] mem[int];
  logic [6:0]  sect[$];
  logic        we_q, acc_q, id, sec, byp, sus;
  logic [7:0]  d;
  int          st, busy, win, ks[$];
  function automatic logic [15:0] rd(input logic [21:0] a);
    if (id) return a[7:0] == 8'h00 ? MANUF : a[7:0] == 8'h01 ? DEVID : {15'h0, a[21]};
    if (sec) return 16'hd2c0 + a[2:0];
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction
  task automatic prog();
    mem[int'(addr)] = rd(addr) & dq;
    busy = 20;
  endtask
  always @(posedge clk) begin
    we_q <= we_n;
    acc_q <= accel;
    dq_out <= (!ce_n && !oe_n) ? rd(addr) : ~dq_out;
    d = dq[7:0];
    if (!rst_n) begin
      st = 0; busy = 0; win = 0; id = 0; sec = 0; byp = 0; sus = 0;
    end else begin
      if (accel != acc_q) byp = accel;
      if (busy > 0) busy--;
      if (win > 0) begin
        win--;
        if (win == 0) begin
          ks.delete();
          foreach (mem[k]) if (k[21:15] inside {sect}) ks.push_back(k);
          foreach (ks[i]) mem.delete(ks[i]);
          busy = 60;
        end
      end
      if (we_n && !we_q && !ce_n && busy == 0) begin
        if (win > 0) begin
          if (d == CMD_SECT_ERASE) begin sect.push_back(addr[21:15]); win = WIN; end
          else begin win = 0; sus = (d == CMD_SUSPEND); end
        end else if (byp) begin
          if (st == 3) begin prog(); st = 0; end
          else if (st == 8 && d == 8'h00) begin byp = 0; st = 0; end
          else st = d == CMD_PROGRAM ? 3 : d == CMD_ID_QUERY ? 8 : 0;
        end else if (st == 3) begin prog(); st = 0; end
        else if (id && d == CMD_RESET) id = 0;
        else if (st == 7) begin sec = !(d == 8'h00); st = 0; end
        else if (st == 0 || st == 4) st = (addr[11:0] == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ? st + 1 : 0;
        else if (st == 1 || st == 5) st = (addr[11:0] == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ? st + 1 : 0;
        else if (st == 6) begin
          st = 0;
          if (d == CMD_CHIP_ERASE) begin mem.delete(); busy = 60; end
          if (d == CMD_SECT_ERASE) begin sect = {addr[21:15]}; win = WIN; end
        end else begin
          st = 0;
          if (addr[11:0] == UNLOCK_ADDR1) begin
            if (d == CMD_ID_QUERY) begin st = sec ? 7 : 0; id = !sec; end
            if (d == CMD_SECURE_IN) sec = 1;
            if (d == CMD_PROGRAM) st = 3;
            if (d == CMD_BYPASS) byp = 1;
            if (d == CMD_ERASE_SETUP) st = 4;
          end
        end
      end
    end
    rdy <= (busy == 0);
  end
endmodule
`default_nettype wire

// ---- tb/nor_flash_command_sequencer_test.sv ----
// Purpose: self-checking bench of the flash command controller
// Assumes: behavioural flash model on the far side
// Notes:   expected {check data, err, data} queued per request
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module nor_flash_command_sequencer_test;
  import flash_cmd_pkg::*;
  localparam logic [15:0] MAN = 16'h00a5; // arbitrary
  localparam logic [15:0] DEV = 16'h5a3c; // arbitrary
  localparam logic [17:0] W   = 18'h0;
  localparam logic [17:0] E   = 18'h10000;
  logic              clk, sys_rst, req_valid, req_ready, resp_valid, resp_err, accel_req;
  logic              acceleration_pin, flash_rst_n, ready_busy_n_output, ce_n, we_n, oe_n, dq_oe_n;
  logic [ADDR_W-1:0] addr, pa;
  logic [DATA_W-1:0] resp_data, dq_o, dq_i, d1, d2;
  logic [17:0]       exp_q[$], e;
  cmd_req_t          req;
  mode_t             mode;
  int                err_count, check_count, cycles;
  nor_flash_cmd_ctrl #(.WINDOW_CYC(200)) i_nor_flash_cmd_ctrl (.clk, .sys_rst, .req_valid, .req, .req_ready,
    .resp_valid, .resp_data, .resp_err, .mode, .accel_req, .acceleration_pin, .flash_rst_n,
    .ready_busy_n_output, .ce_n, .we_n, .oe_n, .addr, .dq_o, .dq_oe_n, .dq_i);
  flash_device_model #(.MANUF(MAN), .DEVID(DEV), .WIN(200)) i_flash_device_model (.clk, .rst_n(flash_rst_n),
    .accel(acceleration_pin), .ce_n, .we_n, .oe_n, .addr, .dq(dq_o), .dq_out(dq_i), .rdy(ready_busy_n_output));
  function automatic logic [17:0] R(input logic [15:0] x);
    return {2'b10, x};
  endfunction
  task automatic op(input op_t o, input logic [21:0] a, input logic [15:0] dd, input logic [17:0] x);
    @(posedge clk); #1;
    req_valid = 1; req = '{o, a, dd};
    while (!req_ready) begin @(posedge clk); #1; end
    exp_q.push_back(x);
    @(posedge clk); #1;
    req_valid = 0;
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin err_count++; complete_run(); end
    if (resp_valid) begin
      if (exp_q.size() == 0) `CHK(resp_valid, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK(resp_err, e[16])
        if (e[17]) `CHK(resp_data, e[15:0])
      end
    end
  end
  initial begin
    sys_rst = 1; req_valid = 0; req = '0; accel_req = 0; err_count = 0; check_count = 0; cycles = 0;
    void'($urandom(32'h72570a8a));
    pa = {7'h05, 15'($urandom)}; d1 = 16'($urandom); d2 = 16'($urandom);
    repeat (8) @(posedge clk);
    #1 sys_rst = 0;
    op(OP_ID_ENTER, pa, 0, W);
    op(OP_ID_READ, 22'h3f0000, 0, R(MAN));
    op(OP_ID_READ, 22'h000101, 0, R(DEV));
    op(OP_ID_READ, 22'h200002, 0, R(16'h0001));
    op(OP_ID_READ, 22'h100002, 0, R(16'h0000));
    op(OP_PROGRAM, pa, d1, E);
    op(OP_RESET, 0, 0, W);
    op(OP_READ, pa, 0, R(16'hffff));
    op(OP_SECURE_ENTER, 0, 0, W);
    op(OP_READ, 22'h000005, 0, R(16'hd2c5));
    op(OP_SECURE_EXIT, 0, 0, W);
    op(OP_READ, 22'h000005, 0, R(16'hffff));
    op(OP_PROGRAM, pa, d1, W);
    op(OP_READ, pa, 0, R(d1));
    op(OP_PROGRAM, pa, d2, W);
    op(OP_READ, pa, 0, R(d1 & d2));
    op(OP_BYPASS_ENTER, 0, 0, W);
    op(OP_PROGRAM, pa + 1, d1, E);
    op(OP_BYPASS_PROG, pa + 1, d1, W);
    op(OP_BYPASS_PROG, pa + 2, d2, W);
    op(OP_BYPASS_EXIT, 0, 0, W);
    op(OP_READ, pa + 2, 0, R(d2));
    accel_req = 1;
    op(OP_BYPASS_PROG, pa + 3, d1, W);
    `CHK(acceleration_pin, 1'b1)
    while (exp_q.size() != 0) begin @(posedge clk); #1; end
    accel_req = 0;
    op(OP_BYPASS_EXIT, 0, 0, W);
    op(OP_READ, pa + 3, 0, R(d1));
    op(OP_CHIP_ERASE, 0, 0, W);
    op(OP_READ, pa + 2, 0, R(16'hffff));
    op(OP_PROGRAM, pa, d1, W);
    op(OP_PROGRAM, 22'h3f0010, d2, W);
    op(OP_SECT_ERASE, {7'h05, 15'h0}, 0, W);
    op(OP_SECT_ADD, {7'h06, 15'h0}, 0, W);
    op(OP_PROGRAM, pa, d1, E);
    repeat (210) @(posedge clk);
    while (!ready_busy_n_output) @(posedge clk);
    op(OP_READ, pa, 0, R(16'hffff));
    op(OP_READ, 22'h3f0010, 0, R(d2));
    op(OP_SECT_ERASE, 22'h3f0010, 0, W);
    op(OP_SUSPEND, 0, 0, W);
    while (exp_q.size() != 0) begin @(posedge clk); #1; end
    @(posedge clk); #1;
    `CHK(mode.suspended, 1'b1)
    `CHK(mode.window_open, 1'b0)
    op(OP_READ, 22'h3f0010, 0, R(d2));
    while (exp_q.size() != 0) begin @(posedge clk); #1; end
    complete_run();
  end
endmodule
`default_nettype wire
